// ---- rtl/tpp_pkg.sv ----
// constants shared by the target parameter pipeline files
package tpp_pkg;

  localparam int DATA_W     = 32;
  localparam int ADDR_W     = 7;
  localparam int NUM_STAGES = 8;
  localparam int NUM_DEST   = 4;

  // register map, word addresses of the serial register port
  localparam logic [ADDR_W-1:0] ADDR_GENERAL_CONFIGURATION  = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_START_CONFIGURATION    = 7'h02;
  localparam logic [ADDR_W-1:0] ADDR_GEAR_FACTOR   = 7'h12;
  localparam logic [ADDR_W-1:0] ADDR_POS_COMPARE   = 7'h32;
  localparam logic [ADDR_W-1:0] ADDR_TARGET_POS    = 7'h37;
  localparam logic [ADDR_W-1:0] ADDR_PIPE_FIRST    = 7'h38;
  localparam logic [ADDR_W-1:0] ADDR_PIPE_LAST     = 7'h3f;
  localparam logic [ADDR_W-1:0] ADDR_WRITEBACK_SEL = 7'h50;

  // destination numbering equals the bit position in the enable field
  localparam int DEST_TARGET   = 0;
  localparam int DEST_POS_COMP = 1;
  localparam int DEST_GEAR     = 2;
  localparam int DEST_GEN_CONF = 3;

  // fields
  localparam int PIPE_EN_LSB   = 16;
  localparam int PIPE_EN_W     = 4;
  localparam int STEP_MODE_LSB = 0;
  localparam int STEP_MODE_W   = 2;
  localparam int WB_SEL_W      = 8;

  localparam logic [STEP_MODE_W-1:0] STEP_MODE_INT_RAMP   = 2'h0;
  localparam logic [STEP_MODE_W-1:0] STEP_MODE_EXT_DIRECT = 2'h1;

  // reset values
  localparam logic [DATA_W-1:0]   RST_WORD   = 32'h0000_0000;
  localparam logic [WB_SEL_W-1:0] RST_WB_SEL = 8'h00;

  // spacing between segment starts, in stages, for a given count of enabled destinations
  localparam logic [2:0] SEG2_STEP = 3'h4;
  localparam logic [2:0] SEG3_STEP = 3'h3;
  localparam logic [2:0] SEG4_STEP = 3'h2;

endpackage : tpp_pkg

// ---- rtl/tpp_seg_map.sv ----
// segment mapping of the eight pipeline stages onto the enabled destinations
`timescale 1ns/100ps
module tpp_seg_map
  import tpp_pkg::*;
(
  input  wire logic [PIPE_EN_W-1:0] pipe_en_i,
  output logic      [11:0]          feed_stage_o,
  output logic      [15:0]          stage_owner_o,
  output logic      [7:0]           seg_last_o
);

  logic [2:0] num_en;

  function automatic logic [2:0] ones_below(input logic [3:0] v, input int d);
    logic [2:0] c;
    c = 3'h0;
    for (int i = 0; i < 4; i++)
      if (i < d && v[i])
        c = c + 3'h1;
    return c;
  endfunction

  // first stage of segment k when n destinations are enabled
  function automatic logic [2:0] seg_start(input logic [2:0] n, input logic [2:0] k);
    logic [2:0] s;
    case (n)
      3'h2:    s = 3'(k * SEG2_STEP);
      3'h3:    s = 3'(k * SEG3_STEP);
      3'h4:    s = 3'(k * SEG4_STEP);
      default: s = 3'h0;
    endcase
    return s;
  endfunction

  function automatic logic [2:0] seg_of_stage(input logic [2:0] n, input int s);
    logic [2:0] k;
    k = 3'h0;
    for (int j = 1; j < 4; j++)
      if (3'(j) < n && 32'(seg_start(n, 3'(j))) <= s)
        k = 3'(j);
    return k;
  endfunction

  function automatic logic [1:0] dest_of_rank(input logic [3:0] v, input logic [2:0] k);
    logic [1:0] d;
    d = 2'h0;
    for (int i = 0; i < 4; i++)
      if (v[i] && ones_below(v, i) == k)
        d = 2'(i);
    return d;
  endfunction

  assign num_en = ones_below(pipe_en_i, 4);

  genvar g;
  generate
    for (g = 0; g < NUM_DEST; g++)
    begin : g_dest
      // lowest enabled destination always sits on stage 0
      assign feed_stage_o[g*3 +: 3] = seg_start(num_en, ones_below(pipe_en_i, g));
    end
    for (g = 0; g < NUM_STAGES; g++)
    begin : g_stage
      assign stage_owner_o[g*2 +: 2] = dest_of_rank(pipe_en_i, seg_of_stage(num_en, g));
      if (g == NUM_STAGES - 1)
      begin : g_tail
        assign seg_last_o[g] = 1'b1;
      end
      else
      begin : g_body
        assign seg_last_o[g] = seg_of_stage(num_en, g) != seg_of_stage(num_en, g + 1);
      end
    end
  endgenerate

endmodule // tpp_seg_map

// ---- rtl/tpp_pipeline.sv ----
// target parameter pipeline with register port, segments and cyclic write-back
`timescale 1ns/100ps
module tpp_pipeline
  import tpp_pkg::*;
(
  input  wire logic                   SYS_CLK_I,
  input  wire logic                   SRST_I,
  input  wire logic                   START_I,
  input  wire logic [ADDR_W-1:0]      REG_ADDR_I,
  input  wire logic                   REG_WR_I,
  input  wire logic [DATA_W-1:0]      REG_WDATA_I,
  output logic      [DATA_W-1:0]      REG_RDATA_O,
  output logic      [DATA_W-1:0]      TARGET_POSITION_O,
  output logic      [DATA_W-1:0]      POS_COMPARE_O,
  output logic      [DATA_W-1:0]      GEAR_FACTOR_O,
  output logic      [DATA_W-1:0]      GENERAL_CONFIGURATION_O,
  output logic      [STEP_MODE_W-1:0] STEP_INPUT_MODE_O
);

  logic [DATA_W-1:0]    general_configuration;
  logic [DATA_W-1:0]    start_configuration;
  logic [DATA_W-1:0]    electronic_gear_factor;
  logic [DATA_W-1:0]    position_compare_value;
  logic [DATA_W-1:0]    target_position;
  logic [DATA_W-1:0]    pipe_stage [NUM_STAGES];
  logic [WB_SEL_W-1:0]  pipe_writeback_select;
  logic [PIPE_EN_W-1:0] pipe_en;
  logic                 pipe_start;
  logic [11:0]          feed_stage;
  logic [15:0]          stage_owner;
  logic [7:0]           seg_last;
  logic [DATA_W-1:0]    dest_value [NUM_DEST];
  logic [DATA_W-1:0]    feed_value [NUM_DEST];
  logic [DATA_W-1:0]    next_rdata;
  logic [NUM_STAGES-1:0] stage_wr;

  assign pipe_en    = start_configuration[PIPE_EN_LSB +: PIPE_EN_W];
  // no destination enabled means no pipeline at all, so stages stay put
  assign pipe_start = START_I && (pipe_en != 4'h0);

  assign dest_value[DEST_TARGET]   = target_position;
  assign dest_value[DEST_POS_COMP] = position_compare_value;
  assign dest_value[DEST_GEAR]     = electronic_gear_factor;
  assign dest_value[DEST_GEN_CONF] = general_configuration;

  tpp_seg_map u_seg_map
  (
    .pipe_en_i     (pipe_en),
    .feed_stage_o  (feed_stage),
    .stage_owner_o (stage_owner),
    .seg_last_o    (seg_last)
  );

  genvar g;
  generate
    for (g = 0; g < NUM_DEST; g++)
    begin : g_feed
      assign feed_value[g] = pipe_stage[feed_stage[g*3 +: 3]];
    end

    for (g = 0; g < NUM_STAGES; g++)
    begin : g_stage
      assign stage_wr[g] = REG_WR_I && (REG_ADDR_I == ADDR_PIPE_FIRST + 7'(g));
      // a start outranks a host write landing on the same stage in that cycle
      always_ff @(posedge SYS_CLK_I)
      begin
        if (SRST_I)
          pipe_stage[g] <= RST_WORD;
        else if (pipe_start)
        begin
          if (pipe_writeback_select[g])
            pipe_stage[g] <= dest_value[stage_owner[g*2 +: 2]];
          else if (!seg_last[g])
            pipe_stage[g] <= pipe_stage[(g + 1) % NUM_STAGES];
        end
        else if (stage_wr[g])
          pipe_stage[g] <= REG_WDATA_I;
      end
    end
  endgenerate

  // destinations take the old stage value in the same edge that shifts the chain
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
      target_position <= RST_WORD;
    else if (pipe_start && pipe_en[DEST_TARGET])
      target_position <= feed_value[DEST_TARGET];
    else if (REG_WR_I && REG_ADDR_I == ADDR_TARGET_POS)
      target_position <= REG_WDATA_I;
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
      position_compare_value <= RST_WORD;
    else if (pipe_start && pipe_en[DEST_POS_COMP])
      position_compare_value <= feed_value[DEST_POS_COMP];
    else if (REG_WR_I && REG_ADDR_I == ADDR_POS_COMPARE)
      position_compare_value <= REG_WDATA_I;
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
      electronic_gear_factor <= RST_WORD;
    else if (pipe_start && pipe_en[DEST_GEAR])
      electronic_gear_factor <= feed_value[DEST_GEAR];
    else if (REG_WR_I && REG_ADDR_I == ADDR_GEAR_FACTOR)
      electronic_gear_factor <= REG_WDATA_I;
  end

  // the whole word is replaced, so step source mode flips on the start edge
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
      general_configuration <= RST_WORD;
    else if (pipe_start && pipe_en[DEST_GEN_CONF])
      general_configuration <= feed_value[DEST_GEN_CONF];
    else if (REG_WR_I && REG_ADDR_I == ADDR_GENERAL_CONFIGURATION)
      general_configuration <= REG_WDATA_I;
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
      start_configuration <= RST_WORD;
    else if (REG_WR_I && REG_ADDR_I == ADDR_START_CONFIGURATION)
      start_configuration <= REG_WDATA_I;
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
      pipe_writeback_select <= RST_WB_SEL;
    else if (REG_WR_I && REG_ADDR_I == ADDR_WRITEBACK_SEL)
      pipe_writeback_select <= REG_WDATA_I[WB_SEL_W-1:0];
  end

  // read data follows the address one cycle later; unmapped words read zero
  always_comb
  begin
    next_rdata = RST_WORD;
    case (REG_ADDR_I)
      ADDR_GENERAL_CONFIGURATION:  next_rdata = general_configuration;
      ADDR_START_CONFIGURATION:    next_rdata = start_configuration;
      ADDR_GEAR_FACTOR:   next_rdata = electronic_gear_factor;
      ADDR_POS_COMPARE:   next_rdata = position_compare_value;
      ADDR_TARGET_POS:    next_rdata = target_position;
      ADDR_WRITEBACK_SEL: next_rdata = {24'h00_0000, pipe_writeback_select};
      default:
      begin
        if (REG_ADDR_I >= ADDR_PIPE_FIRST && REG_ADDR_I <= ADDR_PIPE_LAST)
          next_rdata = pipe_stage[REG_ADDR_I[2:0]];
        else
          next_rdata = RST_WORD;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
      REG_RDATA_O <= RST_WORD;
    else
      REG_RDATA_O <= next_rdata;
  end

  assign TARGET_POSITION_O = target_position;
  assign POS_COMPARE_O     = position_compare_value;
  assign GEAR_FACTOR_O     = electronic_gear_factor;
  assign GENERAL_CONFIGURATION_O    = general_configuration;
  assign STEP_INPUT_MODE_O = general_configuration[STEP_MODE_LSB +: STEP_MODE_W];

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SRST_I);

  sequence s_start_with(logic [3:0] en);
    START_I && pipe_en == en;
  endsequence

  sequence s_plain_start(logic [3:0] en);
    s_start_with(en) ##0 pipe_writeback_select == 8'h00;
  endsequence

  property p_target_from_stage0;
    START_I && pipe_en[DEST_TARGET] |=> target_position == $past(pipe_stage[0]);
  endproperty
  a_target_from_stage0: assert property (p_target_from_stage0)
    else $error("target position not loaded from stage 0");

  property p_chain_shift;
    s_plain_start(4'h1) |=> pipe_stage[0] == $past(pipe_stage[1])
      && pipe_stage[3] == $past(pipe_stage[4])
      && pipe_stage[6] == $past(pipe_stage[7])
      && pipe_stage[7] == $past(pipe_stage[7]);
  endproperty
  a_chain_shift: assert property (p_chain_shift)
    else $error("single chain did not shift by one stage");

  property p_writeback_target;
    s_start_with(4'h1) ##0 pipe_writeback_select == 8'h10
      |=> pipe_stage[4] == $past(target_position) && pipe_stage[3] == $past(pipe_stage[4]);
  endproperty
  a_writeback_target: assert property (p_writeback_target)
    else $error("target position not written back into stage 4");

  property p_segment_border;
    s_plain_start(4'h3) |=> pipe_stage[2] == $past(pipe_stage[3])
      && pipe_stage[3] == $past(pipe_stage[3]) && pipe_stage[4] == $past(pipe_stage[5]);
  endproperty
  a_segment_border: assert property (p_segment_border)
    else $error("value crossed a segment border");

  property p_readback_compare;
    REG_WR_I && REG_ADDR_I == ADDR_POS_COMPARE && !START_I ##1 REG_ADDR_I == ADDR_POS_COMPARE
      |=> REG_RDATA_O == $past(REG_WDATA_I, 2);
  endproperty
  a_readback_compare: assert property (p_readback_compare)
    else $error("position compare readback mismatch");

  property p_disabled_dest_holds;
    START_I && !pipe_en[DEST_GEAR] && !(REG_WR_I && REG_ADDR_I == ADDR_GEAR_FACTOR)
      |=> $stable(electronic_gear_factor);
  endproperty
  a_disabled_dest_holds: assert property (p_disabled_dest_holds)
    else $error("gear factor changed without its pipeline");

  property p_no_pipeline;
    s_start_with(4'h0) ##0 !REG_WR_I |=> $stable(pipe_stage[0]) && $stable(target_position);
  endproperty
  a_no_pipeline: assert property (p_no_pipeline)
    else $error("pipeline moved with no destination enabled");

  property p_two_segments;
    s_start_with(4'h6) |=> position_compare_value == $past(pipe_stage[0])
      && electronic_gear_factor == $past(pipe_stage[4]);
  endproperty
  a_two_segments: assert property (p_two_segments)
    else $error("two segment mapping wrong");

  property p_three_segments;
    s_start_with(4'h7) |=> target_position == $past(pipe_stage[0])
      && position_compare_value == $past(pipe_stage[3])
      && electronic_gear_factor == $past(pipe_stage[6]);
  endproperty
  a_three_segments: assert property (p_three_segments)
    else $error("three segment mapping wrong");

  property p_mode_switch;
    s_start_with(4'h8) |=> STEP_INPUT_MODE_O == $past(pipe_stage[0][STEP_MODE_LSB +: STEP_MODE_W]);
  endproperty
  a_mode_switch: assert property (p_mode_switch)
    else $error("step input mode not switched at start");

  property p_auto_writeback;
    s_start_with(4'hc) ##0 pipe_writeback_select == 8'h41
      |=> pipe_stage[0] == $past(electronic_gear_factor)
      && pipe_stage[6] == $past(general_configuration);
  endproperty
  a_auto_writeback: assert property (p_auto_writeback)
    else $error("write-back picked the wrong destination");

  property p_four_segments;
    s_start_with(4'hf) |=> target_position == $past(pipe_stage[0])
      && position_compare_value == $past(pipe_stage[2])
      && electronic_gear_factor == $past(pipe_stage[4])
      && general_configuration == $past(pipe_stage[6]);
  endproperty
  a_four_segments: assert property (p_four_segments)
    else $error("four segment mapping wrong");

endmodule // tpp_pipeline

// ---- testbench/tpp_host_model.sv ----
// host side model driving the register port and the start pulse
`timescale 1ns/100ps
module tpp_host_model
  import tpp_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic [DATA_W-1:0] rdata_i,
  output logic      [ADDR_W-1:0] addr_o,
  output logic                   wr_o,
  output logic      [DATA_W-1:0] wdata_o,
  output logic                   start_o
);
  initial
  begin
    addr_o  = 7'h00;
    wr_o    = 1'b0;
    wdata_o = 32'h0000_0000;
    start_o = 1'b0;
  end

  // write data is inverted once the strobe drops, so a stale word never looks valid
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wr_o    <= 1'b1;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
  endtask

  // read data belongs to the address taken one edge earlier
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_i);
    addr_o <= a;
    @(posedge clk_i);
    #1;
    d = rdata_i;
  endtask

  // a level held n cycles counts as n back-to-back starts
  task automatic start(input int n);
    @(posedge clk_i);
    start_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    start_o <= 1'b0;
  endtask
endmodule // tpp_host_model

// ---- testbench/tb_top.sv ----
// self-checking bench for the target parameter pipeline
`timescale 1ns/100ps
module tb_top
  import tpp_pkg::*;
;
  logic              clk;
  logic              srst;
  logic [ADDR_W-1:0] addr;
  logic              wr;
  logic              start;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] dout [4];
  logic [1:0]        mode;
  logic [DATA_W-1:0] m_stg [8];
  logic [DATA_W-1:0] m_dst [4];
  logic [3:0]        m_en;
  logic [7:0]        m_wb;
  logic [DATA_W-1:0] rv;
  logic [ADDR_W-1:0] dadr [4];
  int                fail_count;
  int                tests_run;

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  tpp_host_model u_tpp_host_model (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
                                   .wdata_o(wdata), .start_o(start));

  tpp_pipeline u_tpp_pipeline (
    .SYS_CLK_I(clk), .SRST_I(srst), .START_I(start), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .TARGET_POSITION_O(dout[0]),
    .POS_COMPARE_O(dout[1]), .GEAR_FACTOR_O(dout[2]), .GENERAL_CONFIGURATION_O(dout[3]),
    .STEP_INPUT_MODE_O(mode));

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic wrap_up;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  function automatic int seg_step(input int n);
    return (n == 1) ? 8 : (n == 2) ? 4 : (n == 3) ? 3 : 2;
  endfunction

  // j-th enabled destination in ascending bit order
  function automatic int dest_of(input logic [3:0] en, input int j);
    int k;
    k = 0;
    for (int b = 0; b < 4; b++)
    begin
      if (en[b] === 1'b1)
      begin
        if (k == j)
          return b;
        k++;
      end
    end
    return 0;
  endfunction

  task automatic model_start;
    int n;
    int st;
    int j;
    logic [DATA_W-1:0] os [8];
    logic [DATA_W-1:0] od [4];
    n  = $countones(m_en);
    os = m_stg;
    od = m_dst;
    if (n == 0)
      return;
    st = seg_step(n);
    for (int s = 0; s < 8; s++)
    begin
      j = (s / st > n - 1) ? n - 1 : s / st;
      if (m_wb[s])
        m_stg[s] = od[dest_of(m_en, j)];
      else if (!(s == 7 || ((s + 1) % st == 0 && (s + 1) / st < n)))
        m_stg[s] = os[s + 1];
    end
    for (int k = 0; k < n; k++)
      m_dst[dest_of(m_en, k)] = os[k * st];
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up();
  end

  initial
  begin
    int nst;
    srst       = 1'b1;
    fail_count = 0;
    tests_run  = 0;
    dadr       = '{ADDR_TARGET_POS, ADDR_POS_COMPARE, ADDR_GEAR_FACTOR, ADDR_GENERAL_CONFIGURATION};
    void'($urandom(81));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    for (int d = 0; d < 4; d++)
      chk(dout[d], RST_WORD);
    u_tpp_host_model.wr(7'h7f, 32'hdead_beef);
    u_tpp_host_model.rd(7'h7f, rv);
    chk(rv, 32'h0000_0000);
    u_tpp_host_model.rd(ADDR_WRITEBACK_SEL, rv);
    chk(rv, {24'h000000, RST_WB_SEL});
    m_stg = '{default: RST_WORD};
    m_dst = '{default: RST_WORD};
    $display("test reset done");
    for (int c = 0; c < 18; c++)
    begin
      m_en = c[3:0];
      // plain single chain and a known two segment write-back are corner cases
      m_wb = (c % 3 == 0 || c == 1) ? 8'h00 : 8'($urandom);
      if (c == 12)
        m_wb = 8'h41;
      if (c == 16)
      begin
        m_en = 4'h1;
        m_wb = 8'h10;
      end
      if (c == 17)
        m_en = 4'h8;
      for (int s = 0; s < 8; s++)
      begin
        m_stg[s] = $urandom;
        if (c == 17 && s == 0)
          m_stg[s][1:0] = (mode === STEP_MODE_INT_RAMP) ? STEP_MODE_EXT_DIRECT : STEP_MODE_INT_RAMP;
        u_tpp_host_model.wr(ADDR_PIPE_FIRST + 7'(s), m_stg[s]);
      end
      for (int d = 0; d < 4; d++)
      begin
        m_dst[d] = $urandom;
        u_tpp_host_model.wr(dadr[d], m_dst[d]);
      end
      // shadow transfer stays off, so no bow loading or quiet time is owed
      u_tpp_host_model.wr(ADDR_START_CONFIGURATION, {12'h000, m_en, 16'h0000});
      u_tpp_host_model.wr(ADDR_WRITEBACK_SEL, {24'h000000, m_wb});
      u_tpp_host_model.rd(ADDR_WRITEBACK_SEL, rv);
      chk(rv, {24'h000000, m_wb});
      nst = 1 + int'($urandom % 3);
      u_tpp_host_model.start(nst);
      repeat (nst) model_start();
      @(negedge clk);
      for (int d = 0; d < 4; d++)
        chk(dout[d], m_dst[d]);
      chk({30'h0, mode}, {30'h0, m_dst[3][1:0]});
      for (int s = 0; s < 8; s++)
      begin
        u_tpp_host_model.rd(ADDR_PIPE_FIRST + 7'(s), rv);
        chk(rv, m_stg[s]);
      end
      $display("test en=%h wb=%h starts=%0d done", m_en, m_wb, nst);
    end
    wrap_up();
  end
endmodule // tb_top
